// ===== include/dspm_map.svh
// offsets, field positions, encodings and reset values of the debug/serial pin mux
`ifndef DSPM_MAP_SVH
`define DSPM_MAP_SVH

// ---------------------------------------------
// pin indices within the muxed pad vector
// ---------------------------------------------
`define DSPM_PB0 0
`define DSPM_PB2 1
`define DSPM_PC0 2
`define DSPM_PC1 3
`define DSPM_PC2 4
`define DSPM_PC3 5
`define DSPM_PC4 6
`define DSPM_NPADS 7

// ---------------------------------------------
// configuration field positions
// ---------------------------------------------
`define DSPM_PB0_CFG 3:0
`define DSPM_PB2_CFG 11:8
`define DSPM_PC0_CFG 3:0
`define DSPM_PC1_CFG 7:4
`define DSPM_PC2_CFG 11:8
`define DSPM_DBG_GPIO_BIT 5
`define DSPM_REMAP_CH2_BIT 5

// ---------------------------------------------
// encodings
// ---------------------------------------------
`define DSPM_CFG_ALT_PP 4'h9
`define DSPM_CFG_ALT_OD 4'hD
`define DSPM_SC_UART 2'h1
`define DSPM_SC_SPI 2'h2
`define DSPM_SC_TWI 2'h3
`define DSPM_TRC_ASYNC 2'h0
`define DSPM_TRC_SYNC1 2'h1
`define DSPM_TRC_SYNC2 2'h2
`define DSPM_TRC_SYNC4 2'h3

// ---------------------------------------------
// interrupt select defaults and reset values
// ---------------------------------------------
`define DSPM_IRQC_DEFAULT 5'h0F
`define DSPM_EXT_INTERRUPT_D_DEFAULT 5'h10
`define DSPM_NPINS 24
`define DSPM_PAD_RESET 4'h0

`endif

// ===== include/dspm_pkg.sv
// types shared by the debug/serial pin mux
package dspm_pkg;
	typedef struct packed {
		logic out;
		logic oe;
		logic pull_up;
		logic pull_down;
	} dspm_pad_type;

	typedef struct packed {
		logic out;
		logic oe;
	} dspm_drive_type;

	typedef enum logic {
		DSPM_JTAG,
		DSPM_SWD
	} dspm_dbg_mode_type;
endpackage

// ===== rtl/dspm_cfg_decode.sv
// decode of one 4-bit pad configuration field
`timescale 1ns/100ps
`include "dspm_map.svh"
module dspm_cfg_decode
	import dspm_pkg::*;
(
	input  wire logic [3:0] field_in,
	output logic            alt_pp_out,
	output logic            alt_od_out
);
	assign alt_pp_out = (field_in == `DSPM_CFG_ALT_PP);
	assign alt_od_out = (field_in == `DSPM_CFG_ALT_OD);
endmodule

// ===== rtl/dspm_pad_cell.sv
// one registered pad driver: alternate or port drive plus pulls
`timescale 1ns/100ps
`include "dspm_map.svh"
module dspm_pad_cell
	import dspm_pkg::*;
#(
	parameter logic RST_PU = 1'b0,
	parameter logic RST_PD = 1'b0
) (
	input  wire logic           clock_in,
	input  wire logic           resetn_in,
	input  wire logic           use_alt_in,
	input  dspm_drive_type      alt_in,
	input  dspm_drive_type      gpio_in,
	input  wire logic           pull_up_in,
	input  wire logic           pull_down_in,
	output dspm_pad_type        pad_out
);
	dspm_pad_type pad_q;

	// pulls at reset match the default debug function of the pin
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			pad_q <= {2'b00, RST_PU, RST_PD};
		end else if (use_alt_in) begin
			pad_q <= {alt_in.out, alt_in.oe, pull_up_in, pull_down_in};
		end else begin
			pad_q <= {gpio_in.out, gpio_in.oe, pull_up_in, pull_down_in};
		end
	end

	assign pad_out = pad_q;
endmodule

// ===== rtl/dspm_pin_mux.sv
// debug, trace and serial pin function multiplexer
`timescale 1ns/100ps
`include "dspm_map.svh"
//
// Function
// - spi slave data in when spi slave
// - twowire clock open-drain, unless timer ch2 out remapped and enabled
// - uart receive input in uart mode
// - timer b ch2 out needs remap, enable, alt
// - timer b ch2 capture from pin when remapped
// - debug clock: jtag pull-down, else serial wire
// - pc2/pc4 gpio on debug bit, else jtag in jtag mode
// - async trace on pc2 in serial wire
// - pc3 gpio on debug bit or serial wire
// - jtag mode after reset or external reset
// - trace clock on pb0 when enabled, alt
// - trace bit0 on pc1 in sync trace
// - async trace alternatively on pc1
// - pc0 gpio: debug bit or swd, without trace bit1
// - pc0 jtag reset with pull-up in jtag
// - pc0 feeds irq d, pb0 irq a
// - pb0 feeds timer a clock, timer b mask
// - jtag data in pull-up in jtag mode
// - irq c and d pin selectable
module dspm_pin_mux
	import dspm_pkg::*;
(
	input  wire logic                    clock_in,
	input  wire logic                    resetn_in,
	input  wire logic                    external_reset_pin_in,
	input  wire logic [`DSPM_NPADS-1:0]  pads_in,
	output dspm_pad_type [`DSPM_NPADS-1:0] pads_out,
	input  wire logic                    debug_clock_pad_in,
	output dspm_pad_type                 debug_clock_pad_out,
	input  dspm_drive_type [`DSPM_NPADS-1:0] gpio_drive_in,
	output logic [`DSPM_NPADS-1:0]       gpio_read_out,
	input  wire logic [15:0]             portb_low_config_in,
	input  wire logic [15:0]             portc_low_config_in,
	input  wire logic [7:0]              debug_pin_config_in,
	input  wire logic [7:0]              timer_b_remap_option_reg_in,
	input  wire logic                    timer_b_ch2_out_enable_in,
	input  wire logic [1:0]              serial_ctrl1_mode_select_in,
	input  wire logic                    serial_ctrl1_spi_slave_in,
	input  wire logic                    trace_enable_in,
	input  wire logic [1:0]              trace_mode_in,
	input  wire logic                    swd_switch_in,
	input  wire logic                    jtag_switch_in,
	input  wire logic                    jtag_data_out_in,
	input  dspm_drive_type               serial_wire_clock_drive_in,
	input  dspm_drive_type               serial_wire_data_drive_in,
	input  wire logic                    async_trace_out_in,
	input  wire logic                    sync_trace_clock_in,
	input  wire logic                    sync_trace_bit0_in,
	input  wire logic                    sync_trace_bit1_in,
	input  wire logic                    twowire_clock_low_in,
	input  wire logic                    timer_b_channel2_in,
	input  wire logic [`DSPM_NPINS-1:0]  all_pins_in,
	input  wire logic [4:0]              interrupt_c_pin_select_in,
	input  wire logic [4:0]              interrupt_d_pin_select_in,
	output logic                         serial_ctrl1_slave_in_out,
	output logic                         serial_ctrl1_twowire_clock_out,
	output logic                         serial_ctrl1_uart_rx_out,
	output logic                         timer_b_channel2_out,
	output logic                         jtag_clock_out,
	output logic                         jtag_mode_select_out,
	output logic                         jtag_data_in_out,
	output logic                         jtag_reset_n_out,
	output logic                         serial_wire_clock_out,
	output logic                         serial_wire_data_out,
	output logic                         ext_interrupt_a_out,
	output logic                         ext_interrupt_c_out,
	output logic                         ext_interrupt_d_out,
	output logic                         timer_a_ext_clock_out,
	output logic                         timer_b_clock_mask_out,
	output logic                         debug_mode_swd_out
);
	// ---------------------------------------------
	// debug mode
	// ---------------------------------------------
	dspm_dbg_mode_type dbg_mode_q;
	dspm_dbg_mode_type dbg_mode_d;
	logic              swd;
	logic              dbg_gpio;

	always_comb begin
		dbg_mode_d = dbg_mode_q;
		case (dbg_mode_q)
			DSPM_JTAG: begin
				if (swd_switch_in) begin
					dbg_mode_d = DSPM_SWD;
				end
			end
			DSPM_SWD: begin
				if (jtag_switch_in) begin
					dbg_mode_d = DSPM_JTAG;
				end
			end
			default: begin
				dbg_mode_d = DSPM_JTAG;
			end
		endcase
	end

	// external reset wins over any switch request in the same cycle
	always_ff @(posedge clock_in) begin
		if (!resetn_in || !external_reset_pin_in) begin
			dbg_mode_q <= DSPM_JTAG;
		end else begin
			dbg_mode_q <= dbg_mode_d;
		end
	end

	assign swd                = (dbg_mode_q == DSPM_SWD);
	assign dbg_gpio           = debug_pin_config_in[`DSPM_DBG_GPIO_BIT];
	assign debug_mode_swd_out = swd;

	// ---------------------------------------------
	// configuration decode
	// ---------------------------------------------
	logic [3:0] cfg_field [5];
	logic [4:0] alt_pp;
	logic [4:0] alt_od;

	assign cfg_field[0] = portb_low_config_in[`DSPM_PB0_CFG];
	assign cfg_field[1] = portb_low_config_in[`DSPM_PB2_CFG];
	assign cfg_field[2] = portc_low_config_in[`DSPM_PC0_CFG];
	assign cfg_field[3] = portc_low_config_in[`DSPM_PC1_CFG];
	assign cfg_field[4] = portc_low_config_in[`DSPM_PC2_CFG];

	genvar g;
	generate
		for (g = 0; g < 5; g++) begin : g_dec
			dspm_cfg_decode u_dec (
				.field_in   (cfg_field[g]),
				.alt_pp_out (alt_pp[g]),
				.alt_od_out (alt_od[g])
			);
		end
	endgenerate

	// ---------------------------------------------
	// function conditions
	// ---------------------------------------------
	logic remap2;
	logic sc_spi_slave;
	logic sc_uart;
	logic scl_sel;
	logic tim_sel;
	logic async_trc;
	logic sync_trc;
	logic td1_active;
	logic trclk_sel;
	logic td0_sel;
	logic atrc_pc1_sel;
	logic atrc_pc2_sel;

	assign remap2       = timer_b_remap_option_reg_in[`DSPM_REMAP_CH2_BIT];
	assign sc_spi_slave = (serial_ctrl1_mode_select_in == `DSPM_SC_SPI)
	                      && serial_ctrl1_spi_slave_in;
	assign sc_uart      = (serial_ctrl1_mode_select_in == `DSPM_SC_UART);
	assign scl_sel      = (serial_ctrl1_mode_select_in == `DSPM_SC_TWI) && alt_od[1]
	                      && (!timer_b_ch2_out_enable_in || !remap2);
	assign tim_sel      = remap2 && timer_b_ch2_out_enable_in && alt_pp[1];
	assign async_trc    = trace_enable_in && (trace_mode_in == `DSPM_TRC_ASYNC);
	assign sync_trc     = trace_enable_in && (trace_mode_in != `DSPM_TRC_ASYNC);
	assign td1_active   = trace_enable_in && alt_pp[2]
	                      && ((trace_mode_in == `DSPM_TRC_SYNC2)
	                      || (trace_mode_in == `DSPM_TRC_SYNC4));
	assign trclk_sel    = trace_enable_in && alt_pp[0];
	assign td0_sel      = sync_trc && alt_pp[3];
	assign atrc_pc1_sel = async_trc && alt_pp[3];
	assign atrc_pc2_sel = swd && async_trc && alt_pp[4] && !dbg_gpio;

	// ---------------------------------------------
	// pad selection
	// ---------------------------------------------
	logic           [`DSPM_NPADS-1:0] use_alt;
	dspm_drive_type [`DSPM_NPADS-1:0] alt_drv;
	logic           [`DSPM_NPADS-1:0] pu;
	logic           [`DSPM_NPADS-1:0] pd;

	always_comb begin
		use_alt = '0;
		alt_drv = '0;
		pu      = '0;
		pd      = '0;
		use_alt[`DSPM_PB0] = trclk_sel;
		alt_drv[`DSPM_PB0] = '{sync_trace_clock_in, 1'b1};
		// open-drain clock only ever pulls low
		if (scl_sel) begin
			use_alt[`DSPM_PB2] = 1'b1;
			alt_drv[`DSPM_PB2] = '{1'b0, twowire_clock_low_in};
		end else if (tim_sel) begin
			use_alt[`DSPM_PB2] = 1'b1;
			alt_drv[`DSPM_PB2] = '{timer_b_channel2_in, 1'b1};
		end
		// bit1 trace keeps pc0 even against the debug bit
		if (td1_active) begin
			use_alt[`DSPM_PC0] = 1'b1;
			alt_drv[`DSPM_PC0] = '{sync_trace_bit1_in, 1'b1};
		end else if (!dbg_gpio && !swd) begin
			use_alt[`DSPM_PC0] = 1'b1;
			pu[`DSPM_PC0]      = 1'b1;
		end
		if (td0_sel) begin
			use_alt[`DSPM_PC1] = 1'b1;
			alt_drv[`DSPM_PC1] = '{sync_trace_bit0_in, 1'b1};
		end else if (atrc_pc1_sel) begin
			use_alt[`DSPM_PC1] = 1'b1;
			alt_drv[`DSPM_PC1] = '{async_trace_out_in, 1'b1};
		end
		if (!dbg_gpio && !swd) begin
			use_alt[`DSPM_PC2] = 1'b1;
			alt_drv[`DSPM_PC2] = '{jtag_data_out_in, 1'b1};
			use_alt[`DSPM_PC3] = 1'b1;
			pu[`DSPM_PC3]      = 1'b1;
			use_alt[`DSPM_PC4] = 1'b1;
			pu[`DSPM_PC4]      = 1'b1;
		end else if (atrc_pc2_sel) begin
			use_alt[`DSPM_PC2] = 1'b1;
			alt_drv[`DSPM_PC2] = '{async_trace_out_in, 1'b1};
			pu[`DSPM_PC2]      = 1'b1;
		end
		if (!dbg_gpio && swd) begin
			use_alt[`DSPM_PC4] = 1'b1;
			alt_drv[`DSPM_PC4] = serial_wire_data_drive_in;
			pu[`DSPM_PC4]      = 1'b1;
		end
	end

	generate
		for (g = 0; g < `DSPM_NPADS; g++) begin : g_pad
			localparam logic RPU = (g == `DSPM_PC0) || (g == `DSPM_PC3)
			                       || (g == `DSPM_PC4);
			dspm_pad_cell #(
				.RST_PU (RPU),
				.RST_PD (1'b0)
			) u_pad (
				.clock_in     (clock_in),
				.resetn_in    (resetn_in),
				.use_alt_in   (use_alt[g]),
				.alt_in       (alt_drv[g]),
				.gpio_in      (gpio_drive_in[g]),
				.pull_up_in   (pu[g]),
				.pull_down_in (pd[g]),
				.pad_out      (pads_out[g])
			);
		end
	endgenerate

	// debug clock pad has no port function of its own
	dspm_pad_cell #(
		.RST_PU (1'b0),
		.RST_PD (1'b1)
	) u_dbg_clk (
		.clock_in     (clock_in),
		.resetn_in    (resetn_in),
		.use_alt_in   (swd),
		.alt_in       (serial_wire_clock_drive_in),
		.gpio_in      ('0),
		.pull_up_in   (1'b0),
		.pull_down_in (!swd),
		.pad_out      (debug_clock_pad_out)
	);

	// ---------------------------------------------
	// input routing
	// ---------------------------------------------
	logic irq_c_d;
	logic irq_d_d;

	always_comb begin
		irq_c_d = all_pins_in[`DSPM_IRQC_DEFAULT];
		irq_d_d = pads_in[`DSPM_PC0];
		if (interrupt_c_pin_select_in < 5'(`DSPM_NPINS)) begin
			irq_c_d = all_pins_in[interrupt_c_pin_select_in];
		end
		if (interrupt_d_pin_select_in != `DSPM_EXT_INTERRUPT_D_DEFAULT
		    && interrupt_d_pin_select_in < 5'(`DSPM_NPINS)) begin
			irq_d_d = all_pins_in[interrupt_d_pin_select_in];
		end
	end

	// idle levels: uart receive and twowire clock high, the rest low
	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			serial_ctrl1_slave_in_out      <= 1'b0;
			serial_ctrl1_twowire_clock_out <= 1'b1;
			serial_ctrl1_uart_rx_out       <= 1'b1;
			timer_b_channel2_out           <= 1'b0;
		end else begin
			serial_ctrl1_slave_in_out      <= sc_spi_slave && pads_in[`DSPM_PB2];
			serial_ctrl1_twowire_clock_out <= !scl_sel || pads_in[`DSPM_PB2];
			serial_ctrl1_uart_rx_out       <= !sc_uart || pads_in[`DSPM_PB2];
			timer_b_channel2_out           <= remap2 && pads_in[`DSPM_PB2];
		end
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			jtag_clock_out        <= 1'b0;
			jtag_mode_select_out  <= 1'b1;
			jtag_data_in_out      <= 1'b1;
			jtag_reset_n_out      <= 1'b1;
			serial_wire_clock_out <= 1'b0;
			serial_wire_data_out  <= 1'b1;
		end else begin
			jtag_clock_out        <= !swd && debug_clock_pad_in;
			jtag_mode_select_out  <= dbg_gpio || pads_in[`DSPM_PC4];
			jtag_data_in_out      <= dbg_gpio || swd || pads_in[`DSPM_PC3];
			jtag_reset_n_out      <= dbg_gpio || swd || td1_active
			                         || pads_in[`DSPM_PC0];
			serial_wire_clock_out <= swd && debug_clock_pad_in;
			serial_wire_data_out  <= dbg_gpio || pads_in[`DSPM_PC4];
		end
	end

	always_ff @(posedge clock_in) begin
		if (!resetn_in) begin
			ext_interrupt_a_out    <= 1'b0;
			ext_interrupt_c_out    <= 1'b0;
			ext_interrupt_d_out    <= 1'b0;
			timer_a_ext_clock_out  <= 1'b0;
			timer_b_clock_mask_out <= 1'b0;
			gpio_read_out          <= '0;
		end else begin
			ext_interrupt_a_out    <= pads_in[`DSPM_PB0];
			ext_interrupt_c_out    <= irq_c_d;
			ext_interrupt_d_out    <= irq_d_d;
			timer_a_ext_clock_out  <= pads_in[`DSPM_PB0];
			timer_b_clock_mask_out <= pads_in[`DSPM_PB0];
			gpio_read_out          <= pads_in;
		end
	end

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!resetn_in);

	sequence s_ext_reset;
		!external_reset_pin_in;
	endsequence

	sequence s_switch_req;
		dbg_mode_q == DSPM_JTAG && swd_switch_in && external_reset_pin_in;
	endsequence

	a_reset_to_jtag: assert property (s_ext_reset |=> !debug_mode_swd_out)
		else $error("debug port not in jtag after external reset");
	a_switch_to_swd: assert property (s_switch_req |=> debug_mode_swd_out)
		else $error("serial wire switch not taken");
	a_spi_slave_in: assert property (sc_spi_slave |=>
		serial_ctrl1_slave_in_out == $past(pads_in[`DSPM_PB2]))
		else $error("spi slave input not routed");
	a_twowire_od: assert property (scl_sel |=>
		!pads_out[`DSPM_PB2].out && pads_out[`DSPM_PB2].oe == $past(twowire_clock_low_in))
		else $error("twowire clock not open drain");
	a_uart_rx: assert property (sc_uart |=>
		serial_ctrl1_uart_rx_out == $past(pads_in[`DSPM_PB2]))
		else $error("uart receive not routed");
	a_timer_out: assert property (tim_sel && !scl_sel |=>
		pads_out[`DSPM_PB2].oe && pads_out[`DSPM_PB2].out == $past(timer_b_channel2_in))
		else $error("timer channel output missing");
	a_timer_capture: assert property (!remap2 |=> !timer_b_channel2_out)
		else $error("capture input seen without remap");
	a_dbg_clk_pull: assert property (!swd |=> debug_clock_pad_out.pull_down)
		else $error("jtag clock pull-down missing");
	a_pc2_gpio: assert property (dbg_gpio && !td1_active |=>
		pads_out[`DSPM_PC2] == {$past(gpio_drive_in[`DSPM_PC2]), 2'b00})
		else $error("pc2 not gpio with debug bit");
	a_async_pc2: assert property (atrc_pc2_sel |=>
		pads_out[`DSPM_PC2].pull_up && pads_out[`DSPM_PC2].oe)
		else $error("async trace missing on pc2");
	a_pc3_gpio: assert property (swd |=> !pads_out[`DSPM_PC3].pull_up ##0
		jtag_data_in_out)
		else $error("pc3 not released in serial wire");
	a_trace_clock: assert property (trclk_sel |=>
		pads_out[`DSPM_PB0].out == $past(sync_trace_clock_in))
		else $error("trace clock not on pb0");
	a_trace_bit0: assert property (td0_sel |=>
		pads_out[`DSPM_PC1].out == $past(sync_trace_bit0_in))
		else $error("trace bit0 not on pc1");
	a_async_pc1: assert property (atrc_pc1_sel |=>
		pads_out[`DSPM_PC1].out == $past(async_trace_out_in))
		else $error("async trace not on pc1");
	a_pc0_gpio: assert property ((dbg_gpio || swd) && !td1_active |=>
		pads_out[`DSPM_PC0].oe == $past(gpio_drive_in[`DSPM_PC0].oe))
		else $error("pc0 not gpio");
	a_pc0_jtag_reset: assert property (!dbg_gpio && !swd && !td1_active |=>
		pads_out[`DSPM_PC0].pull_up && !pads_out[`DSPM_PC0].oe)
		else $error("jtag reset pin setup wrong");
	a_irq_a: assert property (1'b1 |=>
		ext_interrupt_a_out == $past(pads_in[`DSPM_PB0]))
		else $error("interrupt a not from pb0");
	a_timer_inputs: assert property (1'b1 |=>
		timer_b_clock_mask_out == $past(pads_in[`DSPM_PB0]))
		else $error("pb0 timer inputs disagree");
	a_tdi_pullup: assert property (!swd && !dbg_gpio |=>
		pads_out[`DSPM_PC3].pull_up[*1] ##0 !pads_out[`DSPM_PC3].oe)
		else $error("jtag data in pull-up missing");
	a_irq_d_sel: assert property (interrupt_d_pin_select_in == `DSPM_EXT_INTERRUPT_D_DEFAULT |=>
		ext_interrupt_d_out == $past(pads_in[`DSPM_PC0]))
		else $error("interrupt d default pin wrong");
	a_pb0_default: assert property (!trclk_sel |=>
		pads_out[`DSPM_PB0].out == $past(gpio_drive_in[`DSPM_PB0].out))
		else $error("pb0 not gpio when idle");
endmodule

// ===== sim/dspm_far_peer.sv
// far-side model: debugger and pin peers that settle each shared pad wire
`timescale 1ns/100ps
module dspm_far_peer
	import dspm_pkg::*;
(
	input  wire logic          clock_in,
	input  dspm_pad_type [6:0] pads_out_in,
	input  dspm_pad_type       dbg_pad_in,
	input  wire logic [6:0]    peer_level_in,
	input  wire logic [6:0]    peer_drive_in,
	input  wire logic          peer_clk_in,
	input  wire logic          switch_req_in,
	output logic [6:0]         pads_level_out,
	output logic               dbg_level_out,
	output logic               swd_switch_out
);
	logic toggle_q = 1'b0;
	// a floating pin without pulls must not look stable, so it toggles
	always @(posedge clock_in) toggle_q <= ~toggle_q;
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			if (pads_out_in[i].oe) pads_level_out[i] = pads_out_in[i].out;
			else if (peer_drive_in[i]) pads_level_out[i] = peer_level_in[i];
			else if (pads_out_in[i].pull_up) pads_level_out[i] = 1'b1;
			else if (pads_out_in[i].pull_down) pads_level_out[i] = 1'b0;
			else pads_level_out[i] = toggle_q;
		end
	end
	// debugger clock stands still between frames
	assign dbg_level_out = dbg_pad_in.oe ? dbg_pad_in.out : peer_clk_in;
	// switch sequence reduced to the pulse its detector gives
	always @(posedge clock_in) swd_switch_out <= #1 switch_req_in;
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the debug/serial pin mux
`timescale 1ns/100ps
`include "dspm_map.svh"
module tb_top
	import dspm_pkg::*;
;
	logic                 clock_in = 1'b0;
	logic                 resetn_in, external_reset_pin_in, debug_clock_pad_in, sw_req, clk;
	logic                 timer_b_ch2_out_enable_in, serial_ctrl1_spi_slave_in, trace_enable_in;
	logic                 swd_switch_in, jtag_data_out_in, async_trace_out_in, sync_trace_bit0_in;
	logic                 sync_trace_clock_in, twowire_clock_low_in, timer_b_channel2_in;
	logic [6:0]           pads_in, lvl, drv, gpio_read_out;
	logic [15:0]          portb_low_config_in, portc_low_config_in;
	logic [7:0]           debug_pin_config_in, timer_b_remap_option_reg_in;
	logic [1:0]           serial_ctrl1_mode_select_in, trace_mode_in;
	logic [23:0]          all_pins_in;
	logic [4:0]           interrupt_c_pin_select_in, interrupt_d_pin_select_in;
	dspm_pad_type [6:0]   pads_out;
	dspm_pad_type         debug_clock_pad_out;
	dspm_drive_type [6:0] gpio_drive_in;
	logic                 serial_ctrl1_slave_in_out, serial_ctrl1_twowire_clock_out;
	logic                 serial_ctrl1_uart_rx_out, timer_b_channel2_out, jtag_clock_out;
	logic                 jtag_mode_select_out, jtag_data_in_out, jtag_reset_n_out;
	logic                 serial_wire_clock_out, serial_wire_data_out, ext_interrupt_a_out;
	logic                 ext_interrupt_c_out, ext_interrupt_d_out, timer_a_ext_clock_out;
	logic                 timer_b_clock_mask_out, debug_mode_swd_out;
	logic                 jsw, td1;
	dspm_drive_type       swd_dat;
	int                   failures = 0;
	int                   compares = 0;

	dspm_pin_mux dspm_pin_mux_i (.clock_in, .resetn_in, .external_reset_pin_in, .pads_in,
		.pads_out, .debug_clock_pad_in, .debug_clock_pad_out, .gpio_drive_in, .gpio_read_out,
		.portb_low_config_in, .portc_low_config_in, .debug_pin_config_in,
		.timer_b_remap_option_reg_in, .timer_b_ch2_out_enable_in, .serial_ctrl1_mode_select_in,
		.serial_ctrl1_spi_slave_in, .trace_enable_in, .trace_mode_in, .swd_switch_in,
		.jtag_switch_in(jsw), .jtag_data_out_in, .serial_wire_clock_drive_in(swd_dat),
		.serial_wire_data_drive_in(swd_dat), .async_trace_out_in, .sync_trace_clock_in,
		.sync_trace_bit0_in, .sync_trace_bit1_in(td1), .twowire_clock_low_in,
		.timer_b_channel2_in, .all_pins_in, .interrupt_c_pin_select_in,
		.interrupt_d_pin_select_in, .serial_ctrl1_slave_in_out, .serial_ctrl1_twowire_clock_out,
		.serial_ctrl1_uart_rx_out, .timer_b_channel2_out, .jtag_clock_out, .jtag_mode_select_out,
		.jtag_data_in_out, .jtag_reset_n_out, .serial_wire_clock_out, .serial_wire_data_out,
		.ext_interrupt_a_out, .ext_interrupt_c_out, .ext_interrupt_d_out, .timer_a_ext_clock_out,
		.timer_b_clock_mask_out, .debug_mode_swd_out);
	dspm_far_peer dspm_far_peer_i (.clock_in, .pads_out_in(pads_out),
		.dbg_pad_in(debug_clock_pad_out), .peer_level_in(lvl), .peer_drive_in(drv),
		.peer_clk_in(clk), .switch_req_in(sw_req), .pads_level_out(pads_in),
		.dbg_level_out(debug_clock_pad_in), .swd_switch_out(swd_switch_in));

	always #50 clock_in = ~clock_in;

	task automatic tick(input int n = 1);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task automatic chk_bit(input string name, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic chk_pad(input string name, input logic [3:0] exp, input dspm_pad_type got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// ------------------------------
	// watchdog
	// ------------------------------
	initial begin
		#200us;
		failures++;
		tally_and_finish();
	end

	// ------------------------------
	// scenarios
	// ------------------------------
	initial begin
		{resetn_in, sw_req, clk, lvl, drv, gpio_drive_in, portb_low_config_in, all_pins_in,
			portc_low_config_in, debug_pin_config_in, timer_b_remap_option_reg_in, trace_mode_in,
			timer_b_ch2_out_enable_in, serial_ctrl1_spi_slave_in, trace_enable_in,
			jtag_data_out_in, async_trace_out_in, sync_trace_clock_in, sync_trace_bit0_in,
			twowire_clock_low_in, timer_b_channel2_in, serial_ctrl1_mode_select_in} = '0;
		external_reset_pin_in = 1'b1;
		interrupt_c_pin_select_in = 5'h0F;
		interrupt_d_pin_select_in = 5'h10;
		{jsw, td1, swd_dat} = '0;
		tick(6);
		chk_pad("pc0 pad", 4'h2, pads_out[`DSPM_PC0]);
		chk_pad("pc3 pad", 4'h2, pads_out[`DSPM_PC3]);
		chk_pad("dbg clk pad", 4'h1, debug_clock_pad_out);
		chk_bit("swd mode", 1'b0, debug_mode_swd_out);
		resetn_in = 1'b1;
		serial_ctrl1_spi_slave_in = 1'b1;
		drv = 7'h7F;
		tick(2);
		for (int b = 1; b >= 0; b--) begin
			lvl = {7{b[0]}};
			serial_ctrl1_mode_select_in = 2'h2;
			tick(2);
			chk_bit("spi slave in", b[0], serial_ctrl1_slave_in_out);
			chk_bit("irq a", b[0], ext_interrupt_a_out);
			chk_bit("irq d", b[0], ext_interrupt_d_out);
			chk_bit("timer a clk", b[0], timer_a_ext_clock_out);
			chk_bit("timer b mask", b[0], timer_b_clock_mask_out);
			chk_bit("jtag reset", b[0], jtag_reset_n_out);
			chk_bit("jtag data in", b[0], jtag_data_in_out);
			chk_bit("port read", b[0], gpio_read_out[`DSPM_PB0]);
			chk_bit("jtag mode sel", b[0], jtag_mode_select_out);
			serial_ctrl1_mode_select_in = 2'h1;
			tick();
			chk_bit("uart rx", b[0], serial_ctrl1_uart_rx_out);
		end
		all_pins_in = 24'h00_0028;
		interrupt_c_pin_select_in = 5'h03;
		interrupt_d_pin_select_in = 5'h05;
		tick();
		chk_bit("irq c", 1'b1, ext_interrupt_c_out);
		chk_bit("irq d sel", 1'b1, ext_interrupt_d_out);
		drv[`DSPM_PB2] = 1'b0;
		serial_ctrl1_mode_select_in = 2'h3;
		portb_low_config_in = 16'h0D09;
		timer_b_ch2_out_enable_in = 1'b1;
		twowire_clock_low_in = 1'b1;
		trace_enable_in = 1'b1;
		sync_trace_clock_in = 1'b1;
		clk = 1'b1;
		tick();
		chk_bit("pb2 oe", 1'b1, pads_out[`DSPM_PB2].oe);
		chk_bit("pb2 out", 1'b0, pads_out[`DSPM_PB2].out);
		chk_bit("pb0 oe", 1'b1, pads_out[`DSPM_PB0].oe);
		chk_bit("pb0 out", 1'b1, pads_out[`DSPM_PB0].out);
		chk_bit("jtag clk", 1'b1, jtag_clock_out);
		tick();
		chk_bit("twowire clk", 1'b0, serial_ctrl1_twowire_clock_out);
		timer_b_remap_option_reg_in = 8'h20;
		portb_low_config_in = 16'h0909;
		timer_b_channel2_in = 1'b1;
		tick(2);
		chk_bit("pb2 timer out", 1'b1, pads_out[`DSPM_PB2].out);
		chk_bit("timer b ch2 in", 1'b1, timer_b_channel2_out);
		portb_low_config_in = 16'h0000;
		gpio_drive_in[`DSPM_PB2] = 2'h1;
		tick();
		chk_bit("pb2 port oe", 1'b1, pads_out[`DSPM_PB2].oe);
		chk_bit("pb2 port out", 1'b0, pads_out[`DSPM_PB2].out);
		portc_low_config_in = 16'h0099;
		{sync_trace_bit0_in, td1} = 2'b11;
		for (int m = 1; m < 4; m++) begin
			trace_mode_in = m[1:0];
			tick();
			chk_bit("pc1 trace bit0", 1'b1, pads_out[`DSPM_PC1].out);
			chk_bit("pc0 trace bit1", m > 1, pads_out[`DSPM_PC0].out);
		end
		trace_mode_in = 2'h0;
		sync_trace_bit0_in = 1'b0;
		async_trace_out_in = 1'b1;
		jtag_data_out_in = 1'b1;
		tick();
		chk_bit("pc1 async", 1'b1, pads_out[`DSPM_PC1].out);
		chk_bit("pc2 jtag out", 1'b1, pads_out[`DSPM_PC2].out);
		debug_pin_config_in = 8'h20;
		gpio_drive_in = 14'h3FFF;
		lvl = 7'h00;
		tick(2);
		chk_pad("pc2 port", 4'hC, pads_out[`DSPM_PC2]);
		chk_bit("pc0 port", 1'b1, pads_out[`DSPM_PC0].oe);
		chk_bit("jtag data held", 1'b1, jtag_data_in_out);
		debug_pin_config_in = 8'h00;
		portc_low_config_in = 16'h0900;
		drv[`DSPM_PC4] = 1'b1;
		sw_req = 1'b1;
		tick();
		sw_req = 1'b0;
		tick();
		chk_bit("swd mode on", 1'b1, debug_mode_swd_out);
		tick(2);
		chk_bit("swd clk", 1'b1, serial_wire_clock_out);
		chk_bit("swd data", 1'b0, serial_wire_data_out);
		chk_pad("pc2 async", 4'hE, pads_out[`DSPM_PC2]);
		chk_bit("pc3 port", 1'b1, pads_out[`DSPM_PC3].oe);
		chk_bit("pc0 port swd", 1'b1, pads_out[`DSPM_PC0].oe);
		swd_dat = 2'h3;
		jsw = 1'b1;
		tick();
		chk_pad("pc4 swd data", 4'hE, pads_out[`DSPM_PC4]);
		chk_pad("dbg clk swd", 4'hC, debug_clock_pad_out);
		chk_bit("jtag switch", 1'b0, debug_mode_swd_out);
		{jsw, sw_req} = 2'b01;
		tick();
		sw_req = 1'b0;
		tick();
		external_reset_pin_in = 1'b0;
		tick();
		chk_bit("swd mode off", 1'b0, debug_mode_swd_out);
		external_reset_pin_in = 1'b1;
		tick();
		tally_and_finish();
	end
endmodule
